// ### rtl/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
   // apb register map
   localparam logic [7:0] ADDR_CHAN_SEL = 8'h00;
   localparam logic [7:0] ADDR_CTRL = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
   localparam logic [7:0] ADDR_RESULT = 8'h14;
   // control register fields
   localparam int CTRL_SRC_BIT = 0;
   localparam int CTRL_CLK_BIT = 1;
   localparam int CTRL_PDN_BIT = 2;
   localparam logic [2:0] CTRL_RESET = 3'h4;
   // interrupt bits
   localparam int IRQ_EOC_BIT = 0;
   localparam int IRQ_SEQ_BIT = 1;
   // conversion timing
   localparam logic [4:0] EXT_CONV_CYCLES = 5'h0e;
   localparam int INT_CONV_NS = 1650;
   localparam int CLK_PERIOD_NS = 5;
   localparam int INT_CONV_CYC = (INT_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [8:0] INT_CONV_COUNT = 9'(INT_CONV_CYC);
   localparam int CHANNELS = 4;
   localparam int DATA_W = 12;
   typedef enum {ST_IDLE, ST_CONV, ST_DONE} conv_state_t;
endpackage

// ### rtl/adc_ctrl.sv
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module adc_ctrl (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   input wire logic load_strobe_n,
   input wire logic [3:0] low_data_nibble,
   input wire logic sample_start,
   input wire logic [3:0] hw_channel_pick,
   input wire logic external_conv_clock,
   input wire logic [47:0] sample_data,
   output logic [11:0] data_out,
   output logic data_oe,
   output logic busy,
   output logic first_result_flag,
   output logic conversion_done_pulse,
   output logic irq
);
   logic [3:0] chan_sel;
   logic [2:0] ctrl;
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic [3:0] seq;
   logic [1:0] conv_ch;
   logic [1:0] rd_ptr;
   logic [11:0] results [0:3];
   logic [47:0] held;
   logic [8:0] cnt;
   logic start_q, ext_q, load_q, read_q;
   logic conv_end, seq_end;
   adc_ctrl_pkg::conv_state_t state;

   wire apb_wr = psel && penable && pwrite;
   wire apb_rd = psel && penable && !pwrite;
   wire src_sw = ctrl[adc_ctrl_pkg::CTRL_SRC_BIT];
   wire clk_ext = ctrl[adc_ctrl_pkg::CTRL_CLK_BIT];
   wire pdn_n = ctrl[adc_ctrl_pkg::CTRL_PDN_BIT];
   wire start_rise = sample_start && !start_q;
   wire ext_rise = external_conv_clock && !ext_q;
   wire host_rd = !chip_select_n && !read_strobe_n;
   wire rd_end = !host_rd && read_q;
   wire load_rise = load_strobe_n && !load_q && !chip_select_n && read_strobe_n;

   // next enabled channel at or after index, wrapping
   function automatic logic [1:0] next_ch(input logic [3:0] mask, input logic [1:0] from);
      logic [1:0] idx;
      logic [1:0] res;
      res = from;
      for (int i = 3; i >= 0; i--) begin
         idx = from + 2'(i);
         if (mask[idx]) begin
            res = idx;
         end
      end
      return res;
   endfunction

   // first enabled channel of a mask
   function automatic logic [1:0] first_ch(input logic [3:0] mask);
      return next_ch(mask, 2'h0);
   endfunction

   // edge history registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         start_q <= 1'b0;
         ext_q <= 1'b0;
         load_q <= 1'b1;
         read_q <= 1'b0;
      end else if (clk_en) begin
         start_q <= sample_start;
         ext_q <= external_conv_clock;
         load_q <= load_strobe_n;
         read_q <= host_rd;
      end
   end

   // channel select register, pin write or apb write
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         chan_sel <= 4'h0;
      end else if (clk_en) begin
         if (load_rise) begin
            chan_sel <= low_data_nibble;
         end else if (apb_wr && paddr == adc_ctrl_pkg::ADDR_CHAN_SEL) begin
            chan_sel <= pwdata[3:0];
         end
      end
   end

   // control and mask registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl <= adc_ctrl_pkg::CTRL_RESET;
         irq_mask <= 2'h0;
      end else if (clk_en && apb_wr) begin
         if (paddr == adc_ctrl_pkg::ADDR_CTRL) begin
            ctrl <= pwdata[2:0];
         end else if (paddr == adc_ctrl_pkg::ADDR_IRQ_MASK) begin
            irq_mask <= pwdata[1:0];
         end
      end
   end

   // conversion sequencer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= adc_ctrl_pkg::ST_IDLE;
         seq <= 4'h0;
         conv_ch <= 2'h0;
         cnt <= 9'h000;
         held <= '0;
         busy <= 1'b0;
         conv_end <= 1'b0;
         seq_end <= 1'b0;
      end else if (clk_en) begin
         conv_end <= 1'b0;
         seq_end <= 1'b0;
         case (state)
            adc_ctrl_pkg::ST_IDLE: begin
               if (start_rise && pdn_n) begin
                  seq <= src_sw ? chan_sel : hw_channel_pick;
                  held <= sample_data;
                  conv_ch <= first_ch(src_sw ? chan_sel : hw_channel_pick);
                  cnt <= 9'h000;
                  busy <= 1'b1;
                  state <= (src_sw ? chan_sel : hw_channel_pick) == 4'h0 ?
                     adc_ctrl_pkg::ST_DONE : adc_ctrl_pkg::ST_CONV;
               end
            end
            adc_ctrl_pkg::ST_CONV: begin
               if (clk_ext ? ext_rise : 1'b1) begin
                  if (cnt == (clk_ext ? 9'(adc_ctrl_pkg::EXT_CONV_CYCLES) - 9'h001 :
                        adc_ctrl_pkg::INT_CONV_COUNT - 9'h001)) begin
                     cnt <= 9'h000;
                     conv_end <= 1'b1;
                     conv_ch <= next_ch(seq, conv_ch + 2'h1);
                     if (next_ch(seq, conv_ch + 2'h1) <= conv_ch) begin
                        state <= adc_ctrl_pkg::ST_DONE;
                     end
                  end else begin
                     cnt <= cnt + 9'h001;
                  end
               end
            end
            adc_ctrl_pkg::ST_DONE: begin
               busy <= 1'b0;
               seq_end <= 1'b1;
               state <= adc_ctrl_pkg::ST_IDLE;
            end
            default: state <= adc_ctrl_pkg::ST_IDLE;
         endcase
      end
   end

   // result store per channel
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < adc_ctrl_pkg::CHANNELS; i++) begin
            results[i] <= 12'h000;
         end
      end else if (clk_en && state == adc_ctrl_pkg::ST_CONV && cnt == 9'h000) begin
         // every channel of the sequence lands here as its count restarts
         results[conv_ch] <= held[adc_ctrl_pkg::DATA_W*conv_ch +: adc_ctrl_pkg::DATA_W];
      end
   end

   // done pulse, active low one cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         conversion_done_pulse <= 1'b1;
      end else if (clk_en) begin
         conversion_done_pulse <= !conv_end;
      end
   end

   // output pointer and first flag
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rd_ptr <= 2'h0;
         first_result_flag <= 1'b1;
      end else if (clk_en) begin
         if (start_rise && state == adc_ctrl_pkg::ST_IDLE && pdn_n) begin
            rd_ptr <= first_ch(src_sw ? chan_sel : hw_channel_pick);
            first_result_flag <= 1'b1;
         end else if (rd_end) begin
            rd_ptr <= next_ch(seq, rd_ptr + 2'h1);
            first_result_flag <= next_ch(seq, rd_ptr + 2'h1) == first_ch(seq);
         end
      end
   end

   // parallel data drive
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         data_out <= 12'h000;
         data_oe <= 1'b0;
      end else if (clk_en) begin
         data_oe <= host_rd && load_strobe_n;
         data_out <= results[rd_ptr];
      end
   end

   // sticky interrupt status, set wins over clear
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         irq_stat <= 2'h0;
      end else if (clk_en) begin
         for (int i = 0; i < 2; i++) begin
            if ((i == adc_ctrl_pkg::IRQ_EOC_BIT && conv_end) ||
                (i == adc_ctrl_pkg::IRQ_SEQ_BIT && seq_end)) begin
               irq_stat[i] <= 1'b1;
            end else if (apb_wr && paddr == adc_ctrl_pkg::ADDR_IRQ_STAT && pwdata[i]) begin
               irq_stat[i] <= 1'b0;
            end
         end
      end
   end

   // interrupt output
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         irq <= 1'b0;
      end else if (clk_en) begin
         irq <= |(irq_stat & irq_mask);
      end
   end

   // apb read and response, zero wait
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (psel && !penable) begin
            if (paddr == adc_ctrl_pkg::ADDR_CHAN_SEL) begin
               prdata <= {28'h0, chan_sel};
            end else if (paddr == adc_ctrl_pkg::ADDR_CTRL) begin
               prdata <= {29'h0, ctrl};
            end else if (paddr == adc_ctrl_pkg::ADDR_STATUS) begin
               prdata <= {24'h0, seq, 2'h0, first_result_flag, busy};
            end else if (paddr == adc_ctrl_pkg::ADDR_IRQ_STAT) begin
               prdata <= {30'h0, irq_stat};
            end else if (paddr == adc_ctrl_pkg::ADDR_IRQ_MASK) begin
               prdata <= {30'h0, irq_mask};
            end else if (paddr == adc_ctrl_pkg::ADDR_RESULT) begin
               prdata <= {20'h0, results[rd_ptr]};
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end

   // busy starts one cycle after the start edge
   busy_rise_a: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && start_rise && pdn_n && state == adc_ctrl_pkg::ST_IDLE) |=> busy)
      else $error("busy did not rise");

   // no conversion while powered down
   standby_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && start_rise && !pdn_n && state == adc_ctrl_pkg::ST_IDLE) |=> !busy)
      else $error("conversion started in standby");

   // data drive only during host read
   drive_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
      data_oe |-> $past(host_rd))
      else $error("data driven outside read");

   // done pulse is one cycle low
   done_width_a: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && $fell(conversion_done_pulse)) |=> conversion_done_pulse)
      else $error("done pulse too long");

   // load ignored while deselected
   load_select_a: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && chip_select_n && !(apb_wr && paddr == adc_ctrl_pkg::ADDR_CHAN_SEL))
      |=> $stable(chan_sel))
      else $error("channel select changed while deselected");

   // pin write stores nibble
   load_store_a: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && load_rise) |=> chan_sel == $past(low_data_nibble))
      else $error("nibble not stored");

   // sequence frozen during conversion
   seq_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state == adc_ctrl_pkg::ST_CONV) |=> $stable(seq))
      else $error("sequence changed mid conversion");

   // first flag matches pointer on first channel
   first_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
      (busy && state == adc_ctrl_pkg::ST_CONV) |-> first_result_flag == (rd_ptr == first_ch(seq)))
      else $error("first flag mismatch");

   // selection taken from the chosen source at the start edge
   seq_capture_a: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && start_rise && pdn_n && state == adc_ctrl_pkg::ST_IDLE) |=>
      seq == ($past(src_sw) ? $past(chan_sel) : $past(hw_channel_pick)))
      else $error("sequence not captured at start");

   // busy covers every conversion cycle
   busy_cover_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state == adc_ctrl_pkg::ST_CONV) |-> busy)
      else $error("busy low during conversion");

   // external mode counts only on clock edges
   ext_count_a: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && state == adc_ctrl_pkg::ST_CONV && clk_ext && !ext_rise) |=> $stable(cnt))
      else $error("count moved without external edge");

   // done pulse only follows a channel end
   done_source_a: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && $fell(conversion_done_pulse)) |-> $past(state, 2) == adc_ctrl_pkg::ST_CONV)
      else $error("done pulse without conversion");
endmodule

// ### bench/host_model.sv
`timescale 1ns/1ps
// behavioural host on the parallel pin bus
module host_model (
   input wire logic clk_sys,
   input wire logic [11:0] data_out,
   input wire logic data_oe,
   output logic chip_select_n,
   output logic read_strobe_n,
   output logic load_strobe_n,
   output logic [3:0] low_data_nibble
);
   // idle bus levels
   initial begin
      chip_select_n = 1;
      read_strobe_n = 1;
      load_strobe_n = 1;
      low_data_nibble = 4'h0;
   end
   // nibble write, load rises while select still low
   task write_nibble(input logic cs_n, input logic [3:0] v);
      @(posedge clk_sys);
      chip_select_n <= cs_n;
      load_strobe_n <= 0;
      low_data_nibble <= v;
      repeat (2) @(posedge clk_sys);
      load_strobe_n <= 1;
      @(posedge clk_sys);
      chip_select_n <= 1;
      low_data_nibble <= ~v; // released lines show no stale value
   endtask
   // read with load held high, data taken at the edge enable is seen
   task read_word(input logic cs_n, output logic [11:0] d, output logic oe);
      int n;
      n = 0;
      @(posedge clk_sys);
      chip_select_n <= cs_n;
      read_strobe_n <= 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (data_oe !== 1 && n < 4);
      d = data_out;
      oe = data_oe;
      chip_select_n <= 1;
      read_strobe_n <= 1;
      repeat (2) @(posedge clk_sys);
   endtask
endmodule

// ### bench/tb.sv
`timescale 1ns/1ps
// bench for the converter control block
module tb;
   logic clk_sys = 0;
   logic rst = 1;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, r;
   logic pready, pslverr, chip_select_n, read_strobe_n, load_strobe_n, busy, e, oe;
   logic first_result_flag, conversion_done_pulse, irq, data_oe;
   logic sample_start = 0;
   logic external_conv_clock = 0;
   logic clk_en = 1;
   logic [47:0] sample_data = 48'h444333222111;
   logic [3:0] low_data_nibble;
   logic [3:0] hw_channel_pick = 4'h0;
   logic [11:0] data_out, rdat;
   int error_cnt = 0;
   int tests_run = 0;
   int p, ed, c, t;
   int cyc = 0;
   always #2.5 clk_sys = ~clk_sys;
   adc_ctrl u_adc_ctrl (
      .clk_sys(clk_sys),
      .rst(rst),
      .clk_en(clk_en),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .chip_select_n(chip_select_n),
      .read_strobe_n(read_strobe_n),
      .load_strobe_n(load_strobe_n),
      .low_data_nibble(low_data_nibble),
      .sample_start(sample_start),
      .hw_channel_pick(hw_channel_pick),
      .external_conv_clock(external_conv_clock),
      .sample_data(sample_data),
      .data_out(data_out),
      .data_oe(data_oe),
      .busy(busy),
      .first_result_flag(first_result_flag),
      .conversion_done_pulse(conversion_done_pulse),
      .irq(irq)
   );
   host_model u_host_model (
      .clk_sys(clk_sys),
      .data_out(data_out),
      .data_oe(data_oe),
      .chip_select_n(chip_select_n),
      .read_strobe_n(read_strobe_n),
      .load_strobe_n(load_strobe_n),
      .low_data_nibble(low_data_nibble)
   );
   // one compare for every checked value
   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      tests_run++;
      if (g !== x) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, x, g);
      end
   endtask
   // apb transfer, result left in r and e
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1 && n < 16);
      r = prdata;
      e = pslverr;
      chk("apb ready", 1, pready);
      psel <= 0;
      penable <= 0;
   endtask
   task settle;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
   // start a sequence, count done pulses, rising external clock edges before the first done pulse and busy length
   task run_conv(input bit ext);
      int n;
      n = 0;
      p = 0;
      ed = 0;
      c = 0;
      @(posedge clk_sys);
      sample_start <= 1;
      @(posedge clk_sys);
      sample_start <= 0;
      hw_channel_pick <= 4'hf;
      sample_data <= ~sample_data;
      while (busy !== 1 && n < 8) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      while (busy === 1 && c < 2000) begin
         @(posedge clk_sys);
         if (ext && c % 8 == 7) begin
            external_conv_clock <= ~external_conv_clock;
            if (!external_conv_clock && p == 0) ed++;
         end
         #1;
         c++;
         if (conversion_done_pulse === 0) p++;
      end
      external_conv_clock <= 0;
      sample_data <= ~sample_data;
   endtask
   // verdict and end of run
   task end_sim;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // hang guard
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         end_sim;
      end
   end
   // main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      rst <= 0;
      apb(0, adc_ctrl_pkg::ADDR_CTRL, 0);
      chk("ctrl reset", 32'h4, r);
      apb(0, adc_ctrl_pkg::ADDR_STATUS, 0);
      chk("status reset", 32'h2, r);
      apb(0, 8'h20, 0);
      chk("unmapped err", 1, e);
      $display("test map done");
      u_host_model.write_nibble(1, 4'ha);
      apb(0, adc_ctrl_pkg::ADDR_CHAN_SEL, 0);
      chk("sel unselected", 0, r);
      u_host_model.write_nibble(0, 4'h5);
      apb(0, adc_ctrl_pkg::ADDR_CHAN_SEL, 0);
      chk("sel pins", 5, r);
      clk_en <= 0;
      u_host_model.write_nibble(0, 4'h3);
      clk_en <= 1;
      apb(0, adc_ctrl_pkg::ADDR_CHAN_SEL, 0);
      chk("sel frozen", 5, r);
      $display("test pin write done");
      apb(1, adc_ctrl_pkg::ADDR_IRQ_MASK, 0);
      apb(1, adc_ctrl_pkg::ADDR_CTRL, 7);
      run_conv(1);
      chk("pulses reg", 2, p);
      chk("ext edges", 14, ed);
      apb(0, adc_ctrl_pkg::ADDR_IRQ_STAT, 0);
      chk("irq stat", 3, r);
      settle;
      chk("irq masked", 0, irq);
      apb(1, adc_ctrl_pkg::ADDR_IRQ_MASK, 3);
      settle;
      chk("irq on", 1, irq);
      apb(1, adc_ctrl_pkg::ADDR_IRQ_STAT, 3);
      settle;
      chk("irq cleared", 0, irq);
      chk("first flag", 1, first_result_flag);
      u_host_model.read_word(0, rdat, oe);
      chk("read ch1", 12'h111, rdat);
      settle;
      chk("first low", 0, first_result_flag);
      u_host_model.read_word(0, rdat, oe);
      chk("read ch3", 12'h333, rdat);
      settle;
      chk("first wrap", 1, first_result_flag);
      u_host_model.read_word(1, rdat, oe);
      chk("oe unselected", 0, oe);
      $display("test register sequence done");
      hw_channel_pick <= 4'h8;
      apb(1, adc_ctrl_pkg::ADDR_CTRL, 6);
      run_conv(1);
      chk("pulses pins", 1, p);
      u_host_model.read_word(0, rdat, oe);
      chk("read ch4", 12'h444, rdat);
      $display("test pin sequence done");
      hw_channel_pick <= 4'h6;
      sample_data <= 48'h888777666555;
      apb(1, adc_ctrl_pkg::ADDR_CTRL, 4);
      run_conv(0);
      t = c - 2 * adc_ctrl_pkg::INT_CONV_CYC;
      chk("internal time", 1, t >= 0 && t <= 4);
      chk("pulses internal", 2, p);
      u_host_model.read_word(0, rdat, oe);
      chk("read ch2", 12'h666, rdat);
      u_host_model.read_word(0, rdat, oe);
      chk("read ch3 internal", 12'h777, rdat);
      apb(1, adc_ctrl_pkg::ADDR_CTRL, 0);
      run_conv(0);
      chk("standby busy", 0, c);
      $display("test clock and standby done");
      end_sim;
   end
endmodule
